/* inc/sensor_cfg.svh */
// Purpose: constants of the slow/fast sensor port and its registers
// Assumes: included by the package and by the design files
// Notes: addresses and bit positions are the register map of this block
`ifndef SENSOR_CFG_SVH
`define SENSOR_CFG_SVH
// register addresses, low nibble of the command word
`define ADDR_STATUS 4'h0
`define ADDR_MODE 4'h1
`define ADDR_MOVLIM 4'h2
`define ADDR_NAVX 4'h3
`define ADDR_NAVY 4'h4
// command word: write flag, address field
`define CMD_WRITE_BIT 7
`define CMD_ADDR_HI 3
`define CMD_ADDR_LO 0
// status bits
`define ST_CLICK 0
`define ST_NAV 1
`define ST_RDERR 2
`define ST_W 3
// mode control fields
`define MODE_HI 1
`define MODE_LO 0
`define EN_CLICK 2
`define EN_NAV 3
`define MODE_IDLE_V 2'h0
`define MODE_CLICK_V 2'h1
`define MODE_NAV_V 2'h2
`define MODE_ACQ_V 2'h3
// movement limit fields
`define LIMX_HI 3
`define LIMX_LO 0
`define LIMY_HI 7
`define LIMY_LO 4
// reset values and counts
`define MODE_RST 8'h00
`define MOVLIM_RST 8'h00
`define BYTE_ZERO 8'h00
`define NAV_MAX 8'hFF
`define NAV_ONE 8'h01
`define LIM_ZERO 4'h0
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define WORD_CMD 2'h0
`define WORD_DATA 2'h1
`define WORD_MAX 2'h3
// pixel buffer
`define FIFO_W 8
`define FIFO_D 8
`endif

/* inc/sensor_pkg.sv */
// Purpose: types shared by the sensor port logic
// Assumes: sensor_cfg.svh supplies the encodings
// Notes: port states are Gray coded along idle, slow, fast, lost
package sensor_pkg;
`include "sensor_cfg.svh"
  typedef enum logic [1:0] {
    MODE_IDLE = `MODE_IDLE_V,
    MODE_CLICK = `MODE_CLICK_V,
    MODE_NAV = `MODE_NAV_V,
    MODE_ACQ = `MODE_ACQ_V
  } op_mode_t;
  typedef enum logic [1:0] {
    PORT_IDLE = 2'h0,
    PORT_SLOW = 2'h1,
    PORT_FAST = 2'h3,
    PORT_LOST = 2'h2
  } port_state_t;
endpackage

/* inc/fifo_if.sv */
// Purpose: valid/ready carrier between the port logic and its pixel buffer
// Assumes: one clock domain
// Notes: store side is the buffer, user side the port logic
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 8) ();
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport store(input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user(output in_valid, output in_data, output out_ready,
               input in_ready, input out_valid, input out_data);
endinterface

/* src/sweep_fifo.sv */
// Purpose: pixel buffer between the sensor core and the fast port
// Assumes: D is a power of two
// Notes: ready and empty are registered so that ready comes from a flop
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module sweep_fifo #(
  parameter int W = `FIFO_W,
  parameter int D = `FIFO_D
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // both sides
  fifo_if.store f
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic ready_reg;
  logic empty_reg;
  wire push = f.in_valid & ready_reg;
  wire pop = f.out_ready & ~empty_reg;

  assign f.in_ready = ready_reg;
  assign f.out_valid = ~empty_reg;
  assign f.out_data = mem[rd_ptr_reg];
  assign count_next = count_reg + CW'(push) - CW'(pop);

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= f.in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b1;
      empty_reg <= 1'b1;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      ready_reg <= (count_next != CW'(D));
      empty_reg <= (count_next == '0);
    end
  end
endmodule

/* src/sweep_sensor_spi_control.sv */
// Purpose: slow register port, fast pixel port and event interrupt of a sweep sensor
// Assumes: i_ref_clk far faster than SCK; event inputs are one-cycle pulses
// Notes: SPI pins are sampled by i_ref_clk, SCK edges found after two flops
// What this block does
// R1 - click in click-detect mode pulls the active-low interrupt line
// R2 - reading status clears the pending interrupt and releases the line
// R3 - status is 8 bits naming click, navigation or read error
// R4 - first word of each access is a command carrying a 4-bit address
// R5 - on a write the second word is the value to store
// R6 - on a read the register is shifted out in the data word slot
// R7 - host waits half an SCK period from select low to first fall
// R8 - host stops clocking, waits half a period, then deselects
// R9 - slow select low opens the register port, mode writes included
// R10 - host runs the slow port near 100 kHz, within its limit; the host model clocks SCK at 2.5 MHz (8 cycles of 20 MHz)
// R11 - navigation mode counts X and Y movement since last readout
// R12 - reading a movement register restarts its count
// R13 - movement equal to programmed limit raises a navigation interrupt
// R14 - host steps modes: click-detect, navigation, then acquisition
// R15 - after navigation host sets acquisition and moves to fast port
// R16 - host sets heating and watchdog before fast acquisition; this block has neither; the bench writes address 5
// R17 - read errors raise the interrupt; host checks around acquisition
// R18 - host catches the falling interrupt edge, then reads status; the bench checks irq_n low at fixed points instead
// R19 - both selects low together is forbidden (factory test)
// R20 - SCK idles high, data driven on falls, sampled on rises
// R21 - a word without exactly eight clocks locks the port until reset
// R22 - writes to read-only registers change nothing
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module sweep_sensor_spi_control (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // serial pins
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_slow_port_select_n,
  input wire logic i_fast_port_select_n,
  output logic o_miso,
  output logic o_miso_oe,
  output logic o_irq_n,
  // sensor core events
  input wire logic i_click,
  input wire logic i_move_x,
  input wire logic i_move_y,
  input wire logic i_read_error,
  // pixel stream
  input wire logic i_pixel_valid,
  input wire logic [7:0] i_pixel_data,
  output logic o_pixel_ready,
  // status
  output logic [1:0] o_mode,
  output logic o_link_lost
);
  ////////////////////////////////////////////////////////////////////////
  // pin sampling
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic sck_d_reg;
  wire sck_s = sync2_reg[3];
  wire mosi_s = sync2_reg[2];
  wire sss_n_s = sync2_reg[1];
  wire fss_n_s = sync2_reg[0];
  wire sck_rise = sck_s & ~sck_d_reg;
  wire sck_fall = ~sck_s & sck_d_reg; // see R20
  wire slow_sel = ~sss_n_s & fss_n_s; // see R9
  wire fast_sel = ~fss_n_s & sss_n_s; // see R19

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sck_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {i_sck, i_mosi, i_slow_port_select_n, i_fast_port_select_n};
      sync2_reg <= sync1_reg;
      sck_d_reg <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers and their state
  sensor_pkg::port_state_t state_reg;
  sensor_pkg::port_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [1:0] word_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] cmd_reg;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] mode_reg;
  logic [7:0] movlim_reg;
  logic [7:0] nav_x_reg;
  logic [7:0] nav_y_reg;
  logic [`ST_W-1:0] status_reg;
  logic [`ST_W-1:0] status_next;
  logic miso_reg;
  logic miso_oe_reg;
  logic irq_n_reg;
  logic lost_reg;

  function automatic logic [7:0] reg_read(input logic [3:0] a);
    case (a)
      `ADDR_STATUS: reg_read = {5'h00, status_reg};
      `ADDR_MODE: reg_read = mode_reg;
      `ADDR_MOVLIM: reg_read = movlim_reg;
      `ADDR_NAVX: reg_read = nav_x_reg;
      `ADDR_NAVY: reg_read = nav_y_reg;
      default: reg_read = `BYTE_ZERO;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // word framing
  wire in_slow = (state_reg == sensor_pkg::PORT_SLOW);
  wire in_fast = (state_reg == sensor_pkg::PORT_FAST);
  wire in_xfer = in_slow | in_fast;
  wire [7:0] rx_byte = {rx_reg[6:0], mosi_s};
  wire byte_done = in_slow & sck_rise & (bit_cnt_reg == `BIT_LAST);
  wire cmd_done = byte_done & (word_cnt_reg == `WORD_CMD); // see R4
  wire data_done = byte_done & (word_cnt_reg == `WORD_DATA); // see R5
  wire cmd_wr = rx_byte[`CMD_WRITE_BIT];
  wire [3:0] cmd_addr = rx_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire [3:0] wr_addr = cmd_reg[`CMD_ADDR_HI:`CMD_ADDR_LO];
  wire do_write = data_done & cmd_reg[`CMD_WRITE_BIT];
  wire rd_any = cmd_done & ~cmd_wr;
  wire rd_status = rd_any & (cmd_addr == `ADDR_STATUS);
  wire rd_navx = rd_any & (cmd_addr == `ADDR_NAVX);
  wire rd_navy = rd_any & (cmd_addr == `ADDR_NAVY);
  wire wr_mode = do_write & (wr_addr == `ADDR_MODE); // see R22
  wire wr_movlim = do_write & (wr_addr == `ADDR_MOVLIM); // see R22
  wire [7:0] read_value = reg_read(cmd_addr);
  wire deselect = ~(slow_sel | fast_sel);
  wire cut_short = deselect & (bit_cnt_reg != `BIT_FIRST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sensor_pkg::PORT_IDLE: begin
        if (slow_sel) begin
          state_next = sensor_pkg::PORT_SLOW;
        end else if (fast_sel && o_mode == `MODE_ACQ_V) begin
          state_next = sensor_pkg::PORT_FAST;
        end
      end
      sensor_pkg::PORT_SLOW, sensor_pkg::PORT_FAST: begin
        if (cut_short) begin
          state_next = sensor_pkg::PORT_LOST; // see R21
        end else if (deselect) begin
          state_next = sensor_pkg::PORT_IDLE;
        end
      end
      sensor_pkg::PORT_LOST: state_next = sensor_pkg::PORT_LOST;
      default: state_next = sensor_pkg::PORT_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= sensor_pkg::PORT_IDLE;
      bit_cnt_reg <= `BIT_FIRST;
      word_cnt_reg <= `WORD_CMD;
      rx_reg <= `BYTE_ZERO;
      cmd_reg <= `BYTE_ZERO;
    end else begin
      state_reg <= state_next;
      if (!in_xfer) begin
        bit_cnt_reg <= `BIT_FIRST;
        word_cnt_reg <= `WORD_CMD;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        rx_reg <= rx_byte; // see R20
        if (bit_cnt_reg == `BIT_LAST && word_cnt_reg != `WORD_MAX) begin
          word_cnt_reg <= word_cnt_reg + 2'h1;
        end
      end
      if (cmd_done) begin
        cmd_reg <= rx_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pixel buffer and outgoing shifter
  fifo_if #(.W(`FIFO_W)) pix_if ();
  sweep_fifo #(.W(`FIFO_W), .D(`FIFO_D)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .f(pix_if.store)
  );
  wire fast_load = in_fast & sck_fall & (bit_cnt_reg == `BIT_FIRST);
  wire underrun = fast_load & ~pix_if.out_valid;
  wire [7:0] pop_byte = pix_if.out_valid ? pix_if.out_data : `BYTE_ZERO;
  wire [7:0] shift_src = fast_load ? pop_byte : tx_reg;
  assign pix_if.in_valid = i_pixel_valid;
  assign pix_if.in_data = i_pixel_data;
  assign pix_if.out_ready = fast_load;
  assign o_pixel_ready = pix_if.in_ready;

  always_comb begin
    tx_next = tx_reg;
    if (!in_xfer) begin
      tx_next = `BYTE_ZERO;
    end else if (sck_fall) begin
      tx_next = {shift_src[6:0], 1'b0};
    end else if (cmd_done) begin
      tx_next = rd_any ? read_value : `BYTE_ZERO; // see R6
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_reg <= `BYTE_ZERO;
      miso_reg <= 1'b1;
      miso_oe_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      miso_oe_reg <= (state_next == sensor_pkg::PORT_SLOW) ||
                     (state_next == sensor_pkg::PORT_FAST);
      if (in_xfer && sck_fall) begin
        miso_reg <= shift_src[7]; // see R20
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers, movement and events
  wire in_click_mode = (mode_reg[`MODE_HI:`MODE_LO] == `MODE_CLICK_V);
  wire in_nav_mode = (mode_reg[`MODE_HI:`MODE_LO] == `MODE_NAV_V);
  wire [3:0] lim_x = movlim_reg[`LIMX_HI:`LIMX_LO];
  wire [3:0] lim_y = movlim_reg[`LIMY_HI:`LIMY_LO];
  wire step_x = i_move_x & in_nav_mode;
  wire step_y = i_move_y & in_nav_mode;
  wire [7:0] navx_base = rd_navx ? `BYTE_ZERO : nav_x_reg; // see R12
  wire [7:0] navy_base = rd_navy ? `BYTE_ZERO : nav_y_reg; // see R12
  wire [7:0] navx_next = (step_x && navx_base != `NAV_MAX) ? navx_base + `NAV_ONE : navx_base;
  wire [7:0] navy_next = (step_y && navy_base != `NAV_MAX) ? navy_base + `NAV_ONE : navy_base;
  wire hit_x = step_x & (lim_x != `LIM_ZERO) & (navx_next == {4'h0, lim_x});
  wire hit_y = step_y & (lim_y != `LIM_ZERO) & (navy_next == {4'h0, lim_y});
  wire click_evt = i_click & in_click_mode & mode_reg[`EN_CLICK]; // see R1
  wire nav_evt = (hit_x | hit_y) & mode_reg[`EN_NAV]; // see R13
  wire err_evt = i_read_error | underrun; // see R17
  wire [`ST_W-1:0] st_set = {err_evt, nav_evt, click_evt};
  wire [`ST_W-1:0] st_clr = rd_status ? {`ST_W{1'b1}} : {`ST_W{1'b0}};

  assign status_next = (status_reg & ~st_clr) | st_set; // see R2

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_reg <= `MODE_RST;
      movlim_reg <= `MOVLIM_RST;
      nav_x_reg <= `BYTE_ZERO;
      nav_y_reg <= `BYTE_ZERO;
      status_reg <= '0;
      irq_n_reg <= 1'b1;
      lost_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= rx_byte; // see R9
      end
      if (wr_movlim) begin
        movlim_reg <= rx_byte;
      end
      nav_x_reg <= navx_next; // see R11
      nav_y_reg <= navy_next; // see R11
      status_reg <= status_next; // see R3
      irq_n_reg <= ~|status_next; // see R1
      lost_reg <= (state_next == sensor_pkg::PORT_LOST);
    end
  end

  assign o_miso = miso_reg;
  assign o_miso_oe = miso_oe_reg;
  assign o_irq_n = irq_n_reg;
  assign o_mode = mode_reg[`MODE_HI:`MODE_LO];
  assign o_link_lost = lost_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_irq_tracks_status: assert property ( // see R3
    o_irq_n == ~|status_reg) else $error("irq line disagrees with status");
  a_click_irq_low: assert property ( // see R1
    click_evt |=> !o_irq_n && status_reg[`ST_CLICK])
    else $error("click did not raise irq");
  a_status_read_clear: assert property ( // see R2
    rd_status && st_set == '0 |=> o_irq_n && status_reg == '0)
    else $error("status read did not clear irq");
  a_read_slot_data: assert property ( // see R6
    rd_any |=> tx_reg == $past(read_value))
    else $error("read data not loaded for the data slot");
  a_nav_step_count: assert property ( // see R11
    step_x && !rd_navx && nav_x_reg != `NAV_MAX |=> nav_x_reg == $past(nav_x_reg) + 8'h01)
    else $error("movement not counted");
  a_nav_read_restart: assert property ( // see R12
    rd_navy && !step_y |=> nav_y_reg == `BYTE_ZERO)
    else $error("movement not restarted on read");
  a_nav_limit_irq: assert property ( // see R13
    nav_evt |=> status_reg[`ST_NAV] ##0 !o_irq_n)
    else $error("limit match did not raise irq");
  a_rderr_irq: assert property ( // see R17
    err_evt |=> status_reg[`ST_RDERR] && !o_irq_n)
    else $error("read error not flagged");
  a_miso_on_fall: assert property ( // see R20
    in_xfer && !sck_fall |=> $stable(o_miso))
    else $error("miso moved off a falling edge");
  a_short_word_lock: assert property ( // see R21
    in_xfer && cut_short |=> o_link_lost ##1 o_link_lost [*3])
    else $error("short word did not lock port");
  a_ro_write_kept: assert property ( // see R22
    do_write && !wr_mode && !wr_movlim |=> $stable(mode_reg) && $stable(movlim_reg))
    else $error("read-only write changed a register");

  c_click_then_read: cover property (click_evt ##[1:1000] rd_status);
  c_mode_write: cover property (wr_mode);
  c_nav_event: cover property (nav_evt);
  c_fast_byte: cover property (fast_load && pix_if.out_valid);
endmodule

/* tb/spi_host_model.sv */
// Purpose: host side of the slow and fast serial ports, acting as master
// Assumes: SCK period of 8 reference cycles, 4 low and 4 high
// Notes: read words are handed out on o_rx_valid for one cycle
`timescale 1ns/1ps
module spi_host_model (
  // clock
  input wire logic i_ref_clk,
  // serial pins
  input wire logic i_miso,
  output logic o_sck,
  output logic o_mosi,
  output logic o_sss_n,
  output logic o_fss_n,
  // captured read words
  output logic o_rx_valid,
  output logic [7:0] o_rx_data
);
  initial begin
    o_sck = 1'b1;
    o_mosi = 1'b1;
    o_sss_n = 1'b1;
    o_fss_n = 1'b1;
    o_rx_valid = 1'b0;
    o_rx_data = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask

  // msb first, driven on falls, sampled mid high phase
  task automatic word(input logic [7:0] tx, input int nclk, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nclk; i--) begin
      @(posedge i_ref_clk);
      o_sck <= 1'b0;
      o_mosi <= tx[i];
      wait_clk(4);
      o_sck <= 1'b1;
      wait_clk(2);
      rx[i] = i_miso;
      wait_clk(1);
    end
  endtask

  // one select window; only one select is ever low
  task automatic frame(input logic fast, input logic [7:0] w0, input logic [7:0] w1,
                       input int nwords, input int nclk, input logic rd);
    logic [7:0] rx;
    @(posedge i_ref_clk);
    if (fast) begin
      o_fss_n <= 1'b0;
    end else begin
      o_sss_n <= 1'b0;
    end
    wait_clk(4);
    for (int k = 0; k < nwords; k++) begin
      word((k == 0) ? w0 : w1, nclk, rx);
      if (rd && (fast || k > 0)) begin
        @(posedge i_ref_clk);
        o_rx_valid <= 1'b1;
        o_rx_data <= rx;
        @(posedge i_ref_clk);
        o_rx_valid <= 1'b0;
      end
    end
    wait_clk(4);
    o_sss_n <= 1'b1;
    o_fss_n <= 1'b1;
    o_mosi <= 1'b1;
    wait_clk(4);
  endtask

  task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
    frame(1'b0, {1'b1, 3'h0, addr}, data, 2, 8, 1'b0);
  endtask

  task automatic reg_read(input logic [3:0] addr);
    frame(1'b0, {1'b0, 3'h0, addr}, 8'h00, 2, 8, 1'b1);
  endtask
endmodule

/* tb/sweep_sensor_spi_control_tb.sv */
// Purpose: self-checking bench of the sensor register, event and pixel ports
// Assumes: 20 MHz reference clock, host model as serial master
// Notes: read words are checked against a queue of expected bytes
`timescale 1ns/1ps
`include "sensor_cfg.svh"
module sweep_sensor_spi_control_tb;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic click = 1'b0;
  logic move_x = 1'b0;
  logic move_y = 1'b0;
  logic read_error = 1'b0;
  logic pixel_valid = 1'b0;
  logic [7:0] pixel_data = 8'h00;
  logic sck, mosi, sss_n, fss_n, miso, miso_oe, irq_n, pixel_ready, link_lost, rx_valid;
  logic [1:0] mode;
  logic [7:0] rx_data;
  logic [7:0] exp_q[$];
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  // released line reads as pulled up
  wire miso_line = miso_oe ? miso : 1'b1;

  always #25 i_ref_clk = ~i_ref_clk;

  sweep_sensor_spi_control i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(sck), .i_mosi(mosi),
    .i_slow_port_select_n(sss_n), .i_fast_port_select_n(fss_n), .o_miso(miso),
    .o_miso_oe(miso_oe), .o_irq_n(irq_n), .i_click(click), .i_move_x(move_x),
    .i_move_y(move_y), .i_read_error(read_error), .i_pixel_valid(pixel_valid),
    .i_pixel_data(pixel_data), .o_pixel_ready(pixel_ready), .o_mode(mode),
    .o_link_lost(link_lost));

  spi_host_model i_host (
    .i_ref_clk(i_ref_clk), .i_miso(miso_line), .o_sck(sck), .o_mosi(mosi),
    .o_sss_n(sss_n), .o_fss_n(fss_n), .o_rx_valid(rx_valid), .o_rx_data(rx_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      {read_error, move_y, move_x, click} <= 4'(4'h1 << which);
      @(posedge i_ref_clk);
      {click, move_x, move_y, read_error} <= 4'h0;
      repeat (2) @(posedge i_ref_clk);
    end
  endtask

  // miso, oe, irq_n, ready, lost, 0, mode
  task automatic check_reset();
    chk({miso, miso_oe, irq_n, pixel_ready, link_lost, 1'b0, mode}, 8'hB0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      test_done();
    end else if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("mismatch at %0t: got %h expected none", $time, rx_data);
      end else begin
        chk(rx_data, exp_q.pop_front());
      end
    end
  end

  initial begin
    logic [7:0] d;
    int ny;
    int got;
    void'($urandom(32'h10ec));
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check_reset();
    $display("test reset done");
    i_host.reg_write(`ADDR_MODE, 8'h01);
    pulse(0, 1);
    chk({7'h0, irq_n}, 8'h01);
    i_host.reg_write(`ADDR_MODE, 8'h05);
    chk({6'h0, mode}, 8'h01);
    i_host.reg_write(4'hF, 8'h0A);
    i_host.reg_write(`ADDR_STATUS, 8'h07);
    exp_q.push_back(8'h05);
    i_host.reg_read(`ADDR_MODE);
    exp_q.push_back(8'h00);
    i_host.reg_read(`ADDR_STATUS);
    $display("test registers done");
    pulse(0, 1);
    chk({7'h0, irq_n}, 8'h00);
    exp_q.push_back(8'h01);
    i_host.reg_read(`ADDR_STATUS);
    chk({7'h0, irq_n}, 8'h01);
    $display("test click done");
    i_host.reg_write(`ADDR_MODE, 8'h0A);
    i_host.reg_write(`ADDR_MOVLIM, 8'h03);
    ny = $urandom_range(5, 1);
    pulse(2, ny);
    pulse(1, 2);
    chk({7'h0, irq_n}, 8'h01);
    pulse(1, 1);
    chk({7'h0, irq_n}, 8'h00);
    exp_q.push_back(8'h02);
    i_host.reg_read(`ADDR_STATUS);
    exp_q.push_back(8'h03);
    i_host.reg_read(`ADDR_NAVX);
    exp_q.push_back(8'h00);
    i_host.reg_read(`ADDR_NAVX);
    i_host.reg_write(`ADDR_NAVY, 8'h55);
    exp_q.push_back(8'(ny));
    i_host.reg_read(`ADDR_NAVY);
    $display("test navigation done");
    i_host.reg_write(`ADDR_MODE, 8'h03);
    chk({6'h0, mode}, 8'h03);
    i_host.reg_write(4'h5, 8'($urandom));
    chk({6'h0, mode}, 8'h03);
    pulse(3, 1);
    chk({7'h0, irq_n}, 8'h00);
    exp_q.push_back(8'h04);
    i_host.reg_read(`ADDR_STATUS);
    chk({7'h0, irq_n}, 8'h01);
    pixel_valid <= 1'b1;
    d = 8'($urandom);
    pixel_data <= d;
    got = 0;
    for (int t = 0; t < 40 && got < 8; t++) begin
      @(posedge i_ref_clk);
      if (pixel_ready === 1'b1) begin
        exp_q.push_back(d);
        got++;
        d = 8'($urandom);
        pixel_data <= d;
      end
    end
    @(posedge i_ref_clk);
    chk({7'h0, pixel_ready}, 8'h00);
    pixel_valid <= 1'b0;
    exp_q.push_back(8'h00);
    i_host.frame(1'b1, 8'h00, 8'h00, 9, 8, 1'b1);
    chk({7'h0, irq_n}, 8'h00);
    exp_q.push_back(8'h04);
    i_host.reg_read(`ADDR_STATUS);
    $display("test fast port done");
    i_host.frame(1'b0, 8'h81, 8'h00, 1, 4, 1'b0);
    repeat (4) @(posedge i_ref_clk);
    chk({6'h0, link_lost, miso_oe}, 8'h02);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    check_reset();
    $display("test link lost done");
    chk(8'(exp_q.size()), 8'h00);
    test_done();
  end
endmodule
